/* core/adcpf_defs.vh */
`ifndef ADCPF_DEFS_VH
`define ADCPF_DEFS_VH

// ----------------------------------------
// Register addresses (16-bit address bus)
// ----------------------------------------
`define ADCPF_ADDR_RESULT_LO   16'hFF08
`define ADCPF_ADDR_RESULT_HI   16'hFF09
`define ADCPF_ADDR_MODE        16'hFF28
`define ADCPF_ADDR_CHSEL       16'hFF29
`define ADCPF_ADDR_CMPMODE     16'hFF2A
`define ADCPF_ADDR_THRESH      16'hFF2B

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ADCPF_MODE_RUN_BIT     3'd7
`define ADCPF_MODE_FR_HI       3'd5
`define ADCPF_MODE_FR_LO       3'd3
`define ADCPF_MODE_BOOST_BIT   3'd0
`define ADCPF_CMP_EN_BIT       3'd7
`define ADCPF_CMP_DIR_BIT      3'd6
`define ADCPF_MODE_MASK        8'hB9
`define ADCPF_CHSEL_MASK       8'h03
`define ADCPF_CMP_MASK         8'hC0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ADCPF_RST_REG          8'h00

// ----------------------------------------
// Conversion times in fx periods
// ----------------------------------------
`define ADCPF_TCONV_000        9'd288
`define ADCPF_TCONV_001        9'd240
`define ADCPF_TCONV_010        9'd192
`define ADCPF_TCONV_100        9'd144
`define ADCPF_TCONV_101        9'd120
`define ADCPF_TCONV_110        9'd96
`define ADCPF_RESULT_BITS      4'd10
`define ADCPF_SAMPLE_CYC       9'd1

`endif

/* core/adcpf_ctrl.v */
`timescale 1ns/100ps
`default_nettype none
`include "adcpf_defs.vh"

module adcpf_ctrl (
	input  wire        sys_clk_i,
	input  wire        rst_i,
	input  wire [15:0] bus_addr_i,
	input  wire        bus_wr_i,
	input  wire        bus_rd_i,
	input  wire        bus_bit_op_i,
	input  wire [2:0]  bus_bit_sel_i,
	input  wire [7:0]  bus_wdata_i,
	output reg  [15:0] bus_rdata_o,
	output wire        bus_wait_o,
	input  wire        cmp_decision_i,
	output reg  [9:0]  dac_code_o,
	output reg  [1:0]  analog_sel_o,
	output reg         sample_o,
	output reg         boost_reference_enable_o,
	output reg         converter_active_o,
	output reg         conversion_end_irq_o,
	output reg         result_invalid_o
);

	// ----------------------------------------
	// State encodings
	// ----------------------------------------
	localparam [2:0] ST_IDLE   = 3'b001;
	localparam [2:0] ST_SAMPLE = 3'b010;
	localparam [2:0] ST_BITS   = 3'b100;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg  [7:0]  converter_mode_control;
	reg  [7:0]  input_channel_select;
	reg  [7:0]  power_fail_compare_mode;
	reg  [7:0]  power_fail_threshold;
	reg  [9:0]  conversion_result;
	reg  [9:0]  approx_shift_reg;
	reg  [2:0]  state;
	reg  [2:0]  next_state;
	reg  [8:0]  step_cnt;
	reg  [3:0]  bit_idx;
	reg         wait_done;
	reg         first_unboosted;
	reg         cmp_meta;
	reg         cmp_sync;
	reg  [8:0]  conv_total;
	reg  [8:0]  step_len;
	reg  [9:0]  next_sar;
	reg  [9:0]  sar_trial;

	wire        conversion_run     = converter_mode_control[`ADCPF_MODE_RUN_BIT];
	wire        boost_ref_en       = converter_mode_control[`ADCPF_MODE_BOOST_BIT];
	wire [2:0]  conv_time_sel      = converter_mode_control[`ADCPF_MODE_FR_HI:`ADCPF_MODE_FR_LO];
	wire        compare_enable     = power_fail_compare_mode[`ADCPF_CMP_EN_BIT];
	wire        compare_direction  = power_fail_compare_mode[`ADCPF_CMP_DIR_BIT];

	wire        hit_mode   = (bus_addr_i == `ADCPF_ADDR_MODE);
	wire        hit_chsel  = (bus_addr_i == `ADCPF_ADDR_CHSEL);
	wire        hit_cmp    = (bus_addr_i == `ADCPF_ADDR_CMPMODE);
	wire        hit_thr    = (bus_addr_i == `ADCPF_ADDR_THRESH);
	wire        hit_res    = (bus_addr_i == `ADCPF_ADDR_RESULT_LO);
	wire        ctrl_wr    = bus_wr_i & (hit_mode | hit_chsel | hit_cmp | (hit_thr & ~bus_bit_op_i));
	wire        stall_req  = ctrl_wr | (bus_rd_i & hit_res);
	wire [7:0]  bit_mask   = 8'h01 << bus_bit_sel_i;

	// ----------------------------------------
	// Wait cycle: first cycle of a control write or result read stalls
	// ----------------------------------------
	assign bus_wait_o = stall_req & ~wait_done;

	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wait_done <= 1'b0;
		end else begin
			wait_done <= stall_req & ~wait_done;
		end
	end

	// ----------------------------------------
	// Write commit on the second access cycle
	// ----------------------------------------
	wire        wr_commit = ctrl_wr & wait_done;

	// Merge bit or byte write into old value
	function [7:0] merge_wr;
		input [7:0] old_val;
		input [7:0] mask;
		begin
			if (bus_bit_op_i) begin
				merge_wr = (old_val & ~bit_mask) | (bus_wdata_i & bit_mask);
			end else begin
				merge_wr = bus_wdata_i;
			end
			merge_wr = merge_wr & mask;
		end
	endfunction

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			converter_mode_control  <= `ADCPF_RST_REG;
			input_channel_select    <= `ADCPF_RST_REG;
			power_fail_compare_mode <= `ADCPF_RST_REG;
			power_fail_threshold    <= `ADCPF_RST_REG;
		end else if (wr_commit) begin
			if (hit_mode) begin
				converter_mode_control <= merge_wr(converter_mode_control, `ADCPF_MODE_MASK);
			end
			if (hit_chsel) begin
				input_channel_select <= merge_wr(input_channel_select, `ADCPF_CHSEL_MASK);
			end
			if (hit_cmp) begin
				power_fail_compare_mode <= merge_wr(power_fail_compare_mode, `ADCPF_CMP_MASK);
			end
			if (hit_thr) begin
				power_fail_threshold <= bus_wdata_i;
			end
		end
	end

	// ----------------------------------------
	// Conversion time decode
	// ----------------------------------------
	always @* begin
		case (conv_time_sel)
			3'b000:  conv_total = `ADCPF_TCONV_000;
			3'b001:  conv_total = `ADCPF_TCONV_001;
			3'b010:  conv_total = `ADCPF_TCONV_010;
			3'b100:  conv_total = `ADCPF_TCONV_100;
			3'b101:  conv_total = `ADCPF_TCONV_101;
			3'b110:  conv_total = `ADCPF_TCONV_110;
			default: conv_total = `ADCPF_TCONV_110;
		endcase
		step_len = conv_total / {5'd0, `ADCPF_RESULT_BITS};
	end

	// ----------------------------------------
	// Comparator synchroniser
	// ----------------------------------------
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cmp_meta <= 1'b0;
			cmp_sync <= 1'b0;
		end else begin
			cmp_meta <= cmp_decision_i;
			cmp_sync <= cmp_meta;
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	wire        step_end  = (step_cnt == step_len - 9'd1);
	wire        last_bit  = (bit_idx == 4'd0);
	wire        conv_done = (state == ST_BITS) & step_end & last_bit;
	wire        abort     = wr_commit | ~conversion_run;

	always @* begin
		sar_trial = approx_shift_reg;
		next_sar  = approx_shift_reg;
		if (~cmp_sync) begin
			next_sar[bit_idx] = 1'b0;
		end
		if (~last_bit) begin
			next_sar[bit_idx - 4'd1] = 1'b1;
		end
		case (state)
			ST_IDLE:   next_state = conversion_run ? ST_SAMPLE : ST_IDLE;
			ST_SAMPLE: next_state = ST_BITS;
			ST_BITS:   next_state = conv_done ? ST_SAMPLE : ST_BITS;
			default:   next_state = ST_IDLE;
		endcase
		if (abort) begin
			next_state = conversion_run ? ST_SAMPLE : ST_IDLE;
		end
	end

	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state            <= ST_IDLE;
			step_cnt         <= 9'd0;
			bit_idx          <= 4'd9;
			approx_shift_reg <= 10'h000;
		end else begin
			state <= next_state;
			if (abort | (state != ST_BITS)) begin
				step_cnt         <= 9'd0;
				bit_idx          <= 4'd9;
				approx_shift_reg <= 10'h200;
			end else if (step_end) begin
				step_cnt         <= 9'd0;
				approx_shift_reg <= next_sar;
				if (~last_bit) begin
					bit_idx <= bit_idx - 4'd1;
				end
			end else begin
				step_cnt <= step_cnt + 9'd1;
			end
		end
	end

	// ----------------------------------------
	// Result, compare and interrupt
	// ----------------------------------------
	wire [9:0] final_sar  = {approx_shift_reg[9:1], cmp_sync};
	wire       above_eq   = (final_sar[9:2] >= power_fail_threshold);
	wire       cmp_hit    = compare_direction ? ~above_eq : above_eq;
	wire       irq_go     = ~compare_enable | cmp_hit;

	// Result has no reset: contents undefined after reset
	always @(posedge sys_clk_i) begin
		if (conv_done & ~abort) begin
			conversion_result <= final_sar;
		end
	end

	// ----------------------------------------
	// Interrupt and invalid flag
	// ----------------------------------------

	// End pulse, gated by the compare mode
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			conversion_end_irq_o <= 1'b0;
		end else begin
			conversion_end_irq_o <= conv_done & ~abort & irq_go;
		end
	end

	// First result after an unboosted start is flagged
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			first_unboosted <= 1'b0;
		end else if ((state == ST_IDLE) & conversion_run & ~boost_ref_en) begin
			first_unboosted <= 1'b1;
		end else if (conv_done & ~abort) begin
			first_unboosted <= 1'b0;
		end
	end

	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			result_invalid_o <= 1'b0;
		end else if (conv_done & ~abort) begin
			result_invalid_o <= first_unboosted;
		end
	end

	// ----------------------------------------
	// Analog front-end drive
	// ----------------------------------------
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			dac_code_o <= 10'h000;
		end else begin
			dac_code_o <= approx_shift_reg;
		end
	end

	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			analog_sel_o <= 2'b00;
		end else begin
			analog_sel_o <= input_channel_select[1:0];
		end
	end

	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sample_o <= 1'b0;
		end else begin
			sample_o <= (next_state == ST_SAMPLE);
		end
	end

	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			boost_reference_enable_o <= 1'b0;
		end else begin
			boost_reference_enable_o <= boost_ref_en;
		end
	end

	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			converter_active_o <= 1'b0;
		end else begin
			converter_active_o <= conversion_run;
		end
	end

	// ----------------------------------------
	// Register readback
	// ----------------------------------------
	// Readback follows the address every cycle
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bus_rdata_o <= 16'h0000;
		end else begin
			case (bus_addr_i)
				`ADCPF_ADDR_RESULT_LO: bus_rdata_o <= {conversion_result, 6'h00};
				`ADCPF_ADDR_MODE:      bus_rdata_o <= {8'h00, converter_mode_control};
				`ADCPF_ADDR_CHSEL:     bus_rdata_o <= {8'h00, input_channel_select};
				`ADCPF_ADDR_CMPMODE:   bus_rdata_o <= {8'h00, power_fail_compare_mode};
				`ADCPF_ADDR_THRESH:    bus_rdata_o <= {8'h00, power_fail_threshold};
				default:               bus_rdata_o <= 16'h0000;
			endcase
		end
	end

endmodule
`default_nettype wire

/* bench/adcpf_ctrl_properties.sv */
`timescale 1ns/100ps
`default_nettype none
`include "adcpf_defs.vh"
module adcpf_ctrl_chk (
	input wire logic        sys_clk_i,
	input wire logic        rst_i,
	input wire logic [15:0] bus_addr_i,
	input wire logic        bus_wr_i,
	input wire logic        bus_rd_i,
	input wire logic        bus_bit_op_i,
	input wire logic [15:0] bus_rdata_o,
	input wire logic        bus_wait_o,
	input wire logic [9:0]  dac_code_o,
	input wire logic [1:0]  analog_sel_o,
	input wire logic        sample_o,
	input wire logic        boost_reference_enable_o,
	input wire logic        converter_active_o,
	input wire logic        conversion_end_irq_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	logic [8:0] since;
	logic       ctl;
	logic       rres;
	assign rres = bus_addr_i == `ADCPF_ADDR_RESULT_LO;
	assign ctl  = bus_addr_i >= `ADCPF_ADDR_MODE && bus_addr_i <= `ADCPF_ADDR_THRESH
		&& !(bus_bit_op_i && bus_addr_i == `ADCPF_ADDR_THRESH);
	// Cycles since the last sample pulse
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			since <= 9'h000;
		else if (sample_o)
			since <= 9'h000;
		else if (since != 9'h1FF)
			since <= since + 9'h001;
	end
	write_wait_a: assert property ($rose(bus_wr_i) && ctl |-> bus_wait_o ##1 !bus_wait_o)
		else $error("control write without one wait cycle");
	read_wait_a: assert property ($rose(bus_rd_i) && rres |-> bus_wait_o ##1 !bus_wait_o)
		else $error("result read without one wait cycle");
	result_low_a: assert property (bus_rd_i && rres && !bus_wait_o |-> bus_rdata_o[5:0] == 6'h00)
		else $error("result low bits not zero");
	idle_quiet_a: assert property (!converter_active_o && !$past(converter_active_o)
		|-> !sample_o && !conversion_end_irq_o)
		else $error("conversion activity while stopped");
	conv_time_a: assert property (conversion_end_irq_o |-> since >= 9'd90 && since <= 9'd290)
		else $error("conversion length out of range");
	irq_pulse_a: assert property (conversion_end_irq_o |=> !conversion_end_irq_o)
		else $error("end pulse longer than one cycle");
	msb_first_a: assert property (sample_o |-> ##[0:2] dac_code_o == 10'h200)
		else $error("first step does not try the top bit");
	chan_write_a: assert property (!$stable(analog_sel_o) |-> $past(bus_wr_i) || $past(bus_wr_i, 2))
		else $error("channel changed without a write");
	boost_write_a: assert property (!$stable(boost_reference_enable_o)
		|-> $past(bus_wr_i) || $past(bus_wr_i, 2))
		else $error("reference enable changed without a write");
	irq_c: cover property (conversion_end_irq_o);
	sample_c: cover property (sample_o);
	rread_c: cover property (bus_rd_i && rres && !bus_wait_o);
endmodule
`default_nettype wire

/* bench/adcpf_front_model.sv */
`timescale 1ns/100ps
`default_nettype none
module adcpf_front_model (
	input  wire logic        sys_clk_i,
	input  wire logic        sample_i,
	input  wire logic [1:0]  sel_i,
	input  wire logic [9:0]  code_i,
	input  wire logic [39:0] level_i,
	output logic             cmp_o
);
	logic [9:0] held = 10'h000;
	// Hold the selected input for the whole conversion
	always @(posedge sys_clk_i) if (sample_i) held <= level_i[sel_i*10 +: 10];
	assign cmp_o = held >= code_i;
endmodule
`default_nettype wire

/* bench/adcpf_ctrl_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "adcpf_defs.vh"
module adcpf_ctrl_tb;
	logic        sys_clk_i = 0, rst_i = 1, bus_wr_i = 0, bus_rd_i = 0, bus_bit_op_i = 0, cmp;
	logic [2:0]  bus_bit_sel_i = 3'h0;
	logic [7:0]  bus_wdata_i = 8'h00;
	logic [15:0] bus_addr_i = 16'h0000, bus_rdata_o, rd;
	logic [9:0]  dac;
	logic [1:0]  sel;
	logic        bus_wait_o, sample_o, boost_reference_enable_o, converter_active_o;
	logic        conversion_end_irq_o, result_invalid_o;
	logic [39:0] lvl = 40'h0;
	logic [2:0]  code[6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
	int          tconv[6] = '{288, 240, 192, 144, 120, 96};
	int          fails = 0, checked = 0, w, per, i, d, s, e, t;
	adcpf_ctrl adcpf_ctrl_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus_addr_i(bus_addr_i), .bus_wr_i(bus_wr_i),
		.bus_rd_i(bus_rd_i), .bus_bit_op_i(bus_bit_op_i), .bus_bit_sel_i(bus_bit_sel_i),
		.bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o), .bus_wait_o(bus_wait_o), .cmp_decision_i(cmp),
		.dac_code_o(dac), .analog_sel_o(sel), .sample_o(sample_o),
		.boost_reference_enable_o(boost_reference_enable_o), .converter_active_o(converter_active_o),
		.conversion_end_irq_o(conversion_end_irq_o), .result_invalid_o(result_invalid_o));
	adcpf_front_model adcpf_front_model_i (.sys_clk_i(sys_clk_i), .sample_i(sample_o), .sel_i(sel),
		.code_i(dac), .level_i(lvl), .cmp_o(cmp));
	task automatic finish_test;
		if (fails == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic acc(input logic we, input logic [15:0] a, input logic [7:0] dt, input logic bo);
		@(negedge sys_clk_i);
		bus_addr_i = a;
		bus_wdata_i = dt;
		bus_bit_op_i = bo;
		bus_wr_i = we;
		bus_rd_i = !we;
		w = 0;
		#1;
		while (bus_wait_o !== 1'b0 && w < 4) begin
			@(negedge sys_clk_i);
			w++;
		end
		check(16'(w < 4), 16'h0001, "bus answer");
		if (w >= 4)
			finish_test();
		@(negedge sys_clk_i);
		rd = bus_rdata_o;
		bus_wr_i = 0;
		bus_rd_i = 0;
	endtask
	task automatic wait_irq(input int lim);
		for (d = 1; d <= lim; d++) begin
			@(negedge sys_clk_i);
			if (conversion_end_irq_o === 1'b1)
				return;
		end
		d = 0;
	endtask
	task automatic wait_sample;
		per = 0;
		do begin
			@(negedge sys_clk_i);
			per++;
		end while (sample_o !== 1'b1 && per < 400);
	endtask
	initial forever #20 sys_clk_i = ~sys_clk_i;
	initial begin
		void'($urandom(99284));
		repeat (20) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		rst_i = 0;
		for (i = 0; i < 5; i++) begin
			acc(0, (i < 4) ? `ADCPF_ADDR_MODE + 16'(i) : 16'hFF30, 8'h00, 0);
			check(rd, 16'h0000, "reset value");
		end
		acc(1, `ADCPF_ADDR_CHSEL, 8'hFF, 0);
		acc(0, `ADCPF_ADDR_CHSEL, 8'h00, 0);
		check(rd, 16'h0003, "channel mask");
		for (i = 0; i < 6; i++) begin
			s = $urandom % 4;
			lvl[31:0] = $urandom;
			lvl[39:32] = 8'($urandom);
			acc(1, `ADCPF_ADDR_CHSEL, 8'(s), 0);
			acc(1, `ADCPF_ADDR_MODE, {2'b00, code[i], 3'b001}, 0);
			check(16'(w), 16'h0001, "write wait");
			repeat (350) @(negedge sys_clk_i);
			acc(1, `ADCPF_ADDR_MODE, {2'b10, code[i], 3'b001}, 0);
			@(negedge sys_clk_i);
			check({converter_active_o, boost_reference_enable_o}, 16'h0003, "run and boost");
			wait_sample();
			wait_sample();
			e = 1 + 10 * (tconv[i] / 10);
			check(16'(per >= e && per <= e + 1), 16'h0001, "conversion period");
			wait_irq(400);
			check(16'(d > 0), 16'h0001, "end pulse");
			acc(0, `ADCPF_ADDR_RESULT_LO, 8'h00, 0);
			check(16'(w), 16'h0001, "read wait");
			check(rd, {lvl[s*10 +: 10], 6'h00}, "result");
		end
		acc(1, `ADCPF_ADDR_MODE, 8'h30, 0);
		acc(1, `ADCPF_ADDR_MODE, 8'hB0, 0);
		for (i = 1; i >= 0; i--) begin
			wait_irq(400);
			repeat (2) @(negedge sys_clk_i);
			check({boost_reference_enable_o, result_invalid_o}, 16'(i), "first result flag");
		end
		repeat (40) @(negedge sys_clk_i);
		acc(1, `ADCPF_ADDR_THRESH, 8'h00, 0);
		wait_irq(200);
		check(16'(d >= 88 && d <= 95), 16'h0001, "restart after write");
		repeat (30) @(negedge sys_clk_i);
		acc(1, `ADCPF_ADDR_MODE, 8'h31, 0);
		wait_irq(300);
		check({converter_active_o, boost_reference_enable_o, 8'(d)}, 16'h0100, "stop mid conversion");
		t = 1 + $urandom % 254;
		acc(1, `ADCPF_ADDR_THRESH, 8'(t), 0);
		acc(1, `ADCPF_ADDR_THRESH, 8'(~t), 1);
		check(16'(w), 16'h0000, "bit write wait");
		acc(0, `ADCPF_ADDR_THRESH, 8'h00, 0);
		check(rd, 16'(8'(t)), "threshold");
		repeat (40) @(negedge sys_clk_i);
		acc(1, `ADCPF_ADDR_MODE, 8'hB1, 0);
		for (i = 0; i < 4; i++) begin
			lvl[9:0] = 10'(t * 4 - i % 2);
			acc(1, `ADCPF_ADDR_CHSEL, 8'h00, 0);
			acc(1, `ADCPF_ADDR_CMPMODE, {1'b1, i[1], 6'h00}, 0);
			wait_irq(250);
			check(16'(d > 0), 16'(i % 2 == i / 2), "compare gate");
		end
		finish_test();
	end
	initial begin
		#3ms;
		fails++;
		finish_test();
	end
endmodule
bind adcpf_ctrl adcpf_ctrl_chk adcpf_ctrl_chk_i (.*);
`default_nettype wire
